/* verilog/ttp_overtemp_signal_timer_pin_cfg.sv */
// pin and tach configuration register with the overtemperature timer
//
// Operation
// - boost drives all fans full while asserted
// - fast bit sets tach rate 250 ms
// - continuous bits stop pwm pulse stretching
// - lock makes config bits 3..0 read-only
// - status bit 0 set on assertion, read-clear
// - past 45.52 ms bit 0 is count lsb
// - upper status bits zero until 45.52 ms
// - config register resets to 0x00
// - timer status resets to 0x00
// - limit exceeded raises status event, 0 immediate
// - config bit 0 selects alert or pwm2
`timescale 1ns/1ps
module ttp_overtemp_signal_timer_pin_cfg #(
	parameter logic [25:0] TICK_CYC = 26'(ttp_pkg::TICK_CYCLES),
	parameter logic [25:0] TACH_FAST_CYC = 26'(ttp_pkg::TACH_FAST_CYCLES),
	parameter logic [25:0] TACH_NORM_CYC = 26'(ttp_pkg::TACH_NORM_CYCLES)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// fields held in neighbouring registers
	input wire logic cfg_lock,
	input wire logic [1:0] pin14_func,
	input wire logic [7:0] assert_time_limit,
	// overtemperature pins, active low
	input wire logic pin22_n,
	input wire logic pin14_n,
	// pin routing
	output logic pin22_overtemp_signal,
	output logic pin22_vin25,
	output logic pin14_fan4_speed_input,
	output logic pin14_alert,
	output logic pin14_overtemp_signal,
	output logic pin10_alert,
	output logic pin10_pwm2,
	// fan and tach control
	output logic fans_full_duty,
	output logic fast_tach,
	output logic continuous_tach_ch1,
	output logic continuous_tach_ch2,
	output logic continuous_tach_ch3,
	output logic continuous_tach_ch4,
	output logic [3:0] pwm_stretch_en,
	output logic tach_meas_start,
	// overtemperature events
	output logic overtemp_signal_active,
	output logic assert_limit_event
);
	import ttp_pkg::*;

	typedef struct packed {
		logic [7:0] cfg;
		logic assert_flag_count_lsb;
		logic ot_prev;
		logic over_limit;
		logic [7:0] rdata;
		logic p22_ot;
		logic p22_vin;
		logic p14_tach;
		logic p14_alert;
		logic p14_ot;
		logic limit_evt;
		logic full_duty;
	} ttp_main_st_t;

	ttp_main_st_t s_r;
	ttp_main_st_t s_nxt;

	logic rst_meta_r;
	logic rst_sync_n_r;
	logic ot_now;
	logic ot_rise;
	logic wr_cfg;
	logic rd_stat;
	logic dur_tick;
	logic [DUR_W-1:0] assert_duration_count;
	logic [DUR_W-1:0] assert_len;
	logic [7:0] stat_val;
	logic [PERIOD_W-1:0] tach_period;

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_n_r <= rst_meta_r;
		end
	end

	// overtemp level seen on whichever pin is routed to it
	assign ot_now = (s_r.p22_ot & ~pin22_n) | (s_r.p14_ot & ~pin14_n);
	assign ot_rise = ot_now & ~s_r.ot_prev;
	assign wr_cfg = reg_wr && (reg_addr == ADDR_PIN_CFG);
	assign rd_stat = reg_rd && (reg_addr == ADDR_TMR_STAT);

	// duration time base runs only while asserted
	ttp_tick_gen u_dur_tick (
		.clk(clk),
		.rst_n(rst_sync_n_r),
		.run(ot_now),
		.period(TICK_CYC),
		.tick(dur_tick)
	);

	// accumulated duration, cleared by a status read
	ttp_sat_cnt u_dur_cnt (
		.clk(clk),
		.rst_n(rst_sync_n_r),
		.clr(rd_stat),
		.inc(dur_tick),
		.count(assert_duration_count)
	);

	// length of the current assertion, for the limit check
	ttp_sat_cnt u_len_cnt (
		.clk(clk),
		.rst_n(rst_sync_n_r),
		.clr(ot_rise),
		.inc(dur_tick),
		.count(assert_len)
	);

	// tach measurement cadence
	assign tach_period = s_r.cfg[CFG_FAST_BIT] ? TACH_FAST_CYC :
		TACH_NORM_CYC;

	ttp_tick_gen u_tach_tick (
		.clk(clk),
		.rst_n(rst_sync_n_r),
		.run(1'b1),
		.period(tach_period),
		.tick(tach_meas_start)
	);

	// reported timer value: flag alone until two ticks have elapsed
	always_comb begin
		stat_val = {7'h00, s_r.assert_flag_count_lsb};
		if (assert_duration_count >= REPORT_MIN_TICKS) begin
			stat_val = assert_duration_count;
		end
	end

	always_comb begin
		s_nxt = s_r;

		// config write; locked low nibble keeps its value
		if (wr_cfg) begin
			s_nxt.cfg[CFG_CONT_MSB:CFG_CONT_LSB] =
				reg_wdata[CFG_CONT_MSB:CFG_CONT_LSB];
			if (!cfg_lock) begin
				s_nxt.cfg[CFG_LOCK_MSB:0] =
					reg_wdata[CFG_LOCK_MSB:0];
			end
		end

		// pin 22 and pin 14 function decode
		s_nxt.p22_vin = 1'b1;
		s_nxt.p22_ot = 1'b0;
		s_nxt.p14_tach = 1'b0;
		s_nxt.p14_alert = 1'b0;
		s_nxt.p14_ot = 1'b0;
		unique case (pin14_func)
			P14_TACH_A: begin
				s_nxt.p14_tach = 1'b1;
			end
			P14_OTEMP_SEL: begin
				s_nxt.p14_tach = ~s_r.cfg[CFG_OTEMP_BIT];
				s_nxt.p14_ot = s_r.cfg[CFG_OTEMP_BIT];
			end
			P14_ALERT: begin
				s_nxt.p14_alert = 1'b1;
			end
			P14_UNUSED: begin
				s_nxt.p14_tach = 1'b0;
			end
		endcase
		if (s_r.cfg[CFG_OTEMP_BIT] && pin14_func != P14_OTEMP_SEL) begin
			s_nxt.p22_vin = 1'b0;
			s_nxt.p22_ot = 1'b1;
		end

		// assertion flag; a new assertion beats a read clear
		s_nxt.ot_prev = ot_now;
		if (ot_rise) begin
			s_nxt.assert_flag_count_lsb = 1'b1;
		end else if (rd_stat) begin
			s_nxt.assert_flag_count_lsb = 1'b0;
		end

		// limit check, one event per crossing
		s_nxt.over_limit = ot_now &&
			(assert_time_limit == LIMIT_IMMEDIATE ||
			assert_len > assert_time_limit);
		s_nxt.limit_evt = s_nxt.over_limit & ~s_r.over_limit;

		// fail-safe boost only while pin acts as overtemp input
		s_nxt.full_duty = s_r.cfg[CFG_BOOST_BIT] &
			s_r.cfg[CFG_OTEMP_BIT] & ot_now;

		// read data, unmapped addresses answer zero
		if (reg_rd) begin
			if (reg_addr == ADDR_PIN_CFG) begin
				s_nxt.rdata = s_r.cfg;
			end else if (reg_addr == ADDR_TMR_STAT) begin
				s_nxt.rdata = stat_val;
			end else begin
				s_nxt.rdata = RDATA_NONE;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			s_r <= '0;
			s_r.cfg <= RST_PIN_CFG;
			s_r.assert_flag_count_lsb <= RST_TMR_STAT[0];
			s_r.rdata <= RDATA_NONE;
			s_r.p22_vin <= 1'b1;
			s_r.p14_tach <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// register read
	assign reg_rdata = s_r.rdata;

	// routing outputs
	assign pin22_overtemp_signal = s_r.p22_ot;
	assign pin22_vin25 = s_r.p22_vin;
	assign pin14_fan4_speed_input = s_r.p14_tach;
	assign pin14_alert = s_r.p14_alert;
	assign pin14_overtemp_signal = s_r.p14_ot;
	assign pin10_alert = s_r.cfg[CFG_ALERT_BIT];
	assign pin10_pwm2 = ~s_r.cfg[CFG_ALERT_BIT];

	// fan and tach control
	assign fans_full_duty = s_r.full_duty;
	assign fast_tach = s_r.cfg[CFG_FAST_BIT];
	assign continuous_tach_ch1 = s_r.cfg[CFG_CONT_LSB];
	assign continuous_tach_ch2 = s_r.cfg[CFG_CONT_LSB+1];
	assign continuous_tach_ch3 = s_r.cfg[CFG_CONT_LSB+2];
	assign continuous_tach_ch4 = s_r.cfg[CFG_CONT_MSB];
	// continuous measurement needs no stretched pwm pulse
	assign pwm_stretch_en = ~s_r.cfg[CFG_CONT_MSB:CFG_CONT_LSB];

	// events
	assign overtemp_signal_active = s_r.ot_prev;
	assign assert_limit_event = s_r.limit_evt;
endmodule

/* verilog/ttp_pkg.sv */
// constants shared by the overtemperature timer and pin configuration block
package ttp_pkg;

	// register byte addresses on the register port
	localparam logic [7:0] ADDR_PIN_CFG = 8'h78;
	localparam logic [7:0] ADDR_TMR_STAT = 8'h79;

	// values after power-on reset
	localparam logic [7:0] RST_PIN_CFG = 8'h00;
	localparam logic [7:0] RST_TMR_STAT = 8'h00;
	localparam logic [7:0] RDATA_NONE = 8'h00;

	// fields of pin_and_tach_config
	localparam int CFG_ALERT_BIT = 0;
	localparam int CFG_OTEMP_BIT = 1;
	localparam int CFG_BOOST_BIT = 2;
	localparam int CFG_FAST_BIT = 3;
	localparam int CFG_CONT_LSB = 4;
	localparam int CFG_CONT_MSB = 7;
	localparam int CFG_LOCK_MSB = 3;

	// pin 14 function selector codes
	localparam logic [1:0] P14_TACH_A = 2'h0;
	localparam logic [1:0] P14_OTEMP_SEL = 2'h1;
	localparam logic [1:0] P14_ALERT = 2'h2;
	localparam logic [1:0] P14_UNUSED = 2'h3;

	// clock and time base
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_TIME_US = 22760;
	localparam int REPORT_MIN_TIME_US = 45520;
	localparam int TACH_FAST_MS = 250;
	localparam int TACH_RATE_MULT = 4;
	localparam int TACH_NORM_MS = TACH_FAST_MS * TACH_RATE_MULT;

	// cycle counts derived from the times above
	localparam int PERIOD_W = 26;
	localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int TACH_FAST_CYCLES = TACH_FAST_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TACH_NORM_CYCLES = TACH_NORM_MS * 1000000 / CLK_PERIOD_NS;

	// duration count
	localparam int DUR_W = 8;
	localparam logic [7:0] DUR_MAX = 8'hff;
	localparam logic [7:0] LIMIT_IMMEDIATE = 8'h00;
	localparam logic [7:0] REPORT_MIN_TICKS =
		8'(REPORT_MIN_TIME_US / TICK_TIME_US);

endpackage

/* verilog/ttp_tick_gen.sv */
// free or gated prescaler giving a one-cycle tick every period cycles
`timescale 1ns/1ps
module ttp_tick_gen (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic run,
	input wire logic [ttp_pkg::PERIOD_W-1:0] period,
	// result
	output logic tick
);
	import ttp_pkg::*;

	typedef struct packed {
		logic [PERIOD_W-1:0] cnt;
		logic tick;
	} ttp_tick_st_t;

	ttp_tick_st_t s_r;
	ttp_tick_st_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		// stopped counter restarts a full period on the next run
		if (!run) begin
			s_nxt.cnt = '0;
		end else if (s_r.cnt >= period - 26'h1) begin
			s_nxt.cnt = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 26'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;
endmodule

/* verilog/ttp_sat_cnt.sv */
// saturating duration counter with clear; an increment beside a clear leaves a count of one
`timescale 1ns/1ps
module ttp_sat_cnt (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic clr,
	input wire logic inc,
	// result
	output logic [ttp_pkg::DUR_W-1:0] count
);
	import ttp_pkg::*;

	typedef struct packed {
		logic [DUR_W-1:0] cnt;
	} ttp_cnt_st_t;

	ttp_cnt_st_t s_r;
	ttp_cnt_st_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (clr) begin
			s_nxt.cnt = inc ? 8'h01 : 8'h00;
		end else if (inc && s_r.cnt != DUR_MAX) begin
			s_nxt.cnt = s_r.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign count = s_r.cnt;
endmodule

/* tb/ttp_overtemp_signal_checker.sv */
// assertions on the ports of the timer and pin configuration block
`timescale 1ns/1ps
module ttp_overtemp_signal_checker #(
	parameter logic [25:0] TICK_CYC = 26'h8,
	parameter logic [25:0] TACH_FAST_CYC = 26'h14,
	parameter logic [25:0] TACH_NORM_CYC = 26'h50
) (
	input wire logic clk, rst_n, reg_wr, reg_rd, cfg_lock, pin22_n, pin14_n,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, assert_time_limit,
	input wire logic [1:0] pin14_func,
	input wire logic pin22_overtemp_signal, pin22_vin25, pin14_alert,
	input wire logic pin14_fan4_speed_input, pin14_overtemp_signal,
	input wire logic pin10_alert, pin10_pwm2, fans_full_duty, fast_tach,
	input wire logic continuous_tach_ch1, continuous_tach_ch2,
	input wire logic continuous_tach_ch3, continuous_tach_ch4,
	input wire logic [3:0] pwm_stretch_en,
	input wire logic tach_meas_start, overtemp_signal_active,
	input wire logic assert_limit_event
);
	logic [3:0] cont;
	logic cfg_wr;
	assign cont = {continuous_tach_ch4, continuous_tach_ch3,
		continuous_tach_ch2, continuous_tach_ch1};
	assign cfg_wr = reg_wr && reg_addr == 8'h78;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_pwm2_inverse: assert property (pin10_pwm2 == !pin10_alert)
		else $error("pwm2 not inverse of alert");
	a_stretch_off: assert property (pwm_stretch_en == ~cont)
		else $error("stretch not inverse of continuous");
	a_pin22_excl: assert property (pin22_vin25 == !pin22_overtemp_signal)
		else $error("pin 22 function not exclusive");
	a_pin14_single: assert property ($onehot0({pin14_fan4_speed_input,
		pin14_alert, pin14_overtemp_signal}))
		else $error("pin 14 has two functions");
	a_boost_cause: assert property (fans_full_duty |-> overtemp_signal_active)
		else $error("full duty without overtemp");
	a_event_pulse: assert property (assert_limit_event |=> !assert_limit_event)
		else $error("limit event longer than one cycle");
	a_lock_holds: assert property (cfg_wr && cfg_lock |=> $stable(fast_tach))
		else $error("locked bit changed");
	a_wr_update: assert property (cfg_wr && !cfg_lock |=>
		{cont, fast_tach} == $past(reg_wdata[7:3]))
		else $error("config write not applied");
	a_upper_free: assert property (cfg_wr |=> cont == $past(reg_wdata[7:4]))
		else $error("continuous bits not written");
	a_tach_space: assert property (tach_meas_start |=> !tach_meas_start [*8])
		else $error("tach starts too close");
	c_event: cover property (assert_limit_event);
	c_boost: cover property (fans_full_duty);
	c_fast: cover property (tach_meas_start && fast_tach);
endmodule
bind ttp_overtemp_signal_timer_pin_cfg ttp_overtemp_signal_checker #(.TICK_CYC(TICK_CYC),
	.TACH_FAST_CYC(TACH_FAST_CYC), .TACH_NORM_CYC(TACH_NORM_CYC)) u_chk (.*);

/* tb/ttp_otemp_src.sv */
// overtemperature source on the two pins, released lines pulled high
`timescale 1ns/1ps
module ttp_otemp_src (
	// control
	input wire logic clk,
	input wire logic active,
	input wire logic on_pin14,
	// pins, active low
	output logic pin22_n,
	output logic pin14_n
);
	// follows the request without a second falling-edge process
	assign pin22_n = !(active && !on_pin14);
	assign pin14_n = !(active && on_pin14);
endmodule

/* tb/ttp_overtemp_signal_timer_pin_cfg_test.sv */
// register sequence bench for the timer and pin configuration block
`timescale 1ns/1ps
module ttp_overtemp_signal_timer_pin_cfg_test;
	import ttp_pkg::*;
	logic clk, rst_n, reg_wr, reg_rd, cfg_lock, pin22_n, pin14_n, ot_req;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, assert_time_limit;
	logic [1:0] pin14_func;
	logic pin22_overtemp_signal, pin22_vin25, pin14_fan4_speed_input;
	logic pin14_alert, pin14_overtemp_signal, pin10_alert, pin10_pwm2;
	logic fans_full_duty, fast_tach, continuous_tach_ch1, continuous_tach_ch2;
	logic continuous_tach_ch3, continuous_tach_ch4, tach_meas_start;
	logic overtemp_signal_active, assert_limit_event;
	logic [3:0] pwm_stretch_en;
	logic ot_pin14;
	logic [4:0] route [8] = '{5'h0c, 5'h0c, 5'h0a, 5'h08,
		5'h14, 5'h09, 5'h12, 5'h10};
	int err_count, compares, evs, n;
	ttp_overtemp_signal_timer_pin_cfg #(.TICK_CYC(26'h8), .TACH_FAST_CYC(26'h14),
		.TACH_NORM_CYC(26'h50)) uut (.*);
	ttp_otemp_src src (.clk(clk), .active(ot_req), .on_pin14(ot_pin14),
		.pin22_n(pin22_n), .pin14_n(pin14_n));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) if (assert_limit_event === 1'b1) evs++;
	task close_out;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		chk(nm, e, reg_rdata);
	endtask
	task hold(input int c);
		ot_req = 1'b1;
		repeat (c) @(negedge clk);
		ot_req = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task gap;
		n = 1;
		while (tach_meas_start !== 1'b1) @(negedge clk);
		@(negedge clk);
		while (tach_meas_start !== 1'b1) begin
			n++;
			@(negedge clk);
		end
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		close_out;
	end
	initial begin
		{rst_n, reg_wr, reg_rd, cfg_lock, ot_req, pin14_func} = 7'h00;
		{reg_addr, reg_wdata, assert_time_limit} = 24'h000000;
		ot_pin14 = 1'b0;
		err_count = 0;
		compares = 0;
		evs = 0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		chk("reset pins", 8'h7f, {1'b0, pin22_vin25, pin14_fan4_speed_input,
			pin10_pwm2, pwm_stretch_en});
		rd(ADDR_PIN_CFG, 8'h00, "config reset");
		rd(ADDR_TMR_STAT, 8'h00, "status reset");
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			pin14_func = 2'(i);
			wr(ADDR_PIN_CFG, {6'h00, i[2], 1'b0});
			chk("routing", {3'h0, route[i]}, {3'h0, pin22_overtemp_signal,
				pin22_vin25, pin14_fan4_speed_input, pin14_alert,
				pin14_overtemp_signal});
		end
		$display("routing test done");
		wr(ADDR_PIN_CFG, 8'h5b);
		chk("stretch", 8'h0a, {4'h0, pwm_stretch_en});
		chk("pin10 alert", 8'h01, {7'h00, pin10_alert});
		cfg_lock = 1'b1;
		wr(ADDR_PIN_CFG, 8'ha4);
		rd(ADDR_PIN_CFG, 8'hab, "locked write");
		cfg_lock = 1'b0;
		gap;
		gap;
		chk("fast tach gap", 8'h14, 8'(n));
		wr(ADDR_PIN_CFG, 8'h06);
		gap;
		gap;
		chk("normal tach gap", 8'h50, 8'(n));
		$display("config test done");
		pin14_func = 2'h0;
		ot_req = 1'b1;
		repeat (2) @(negedge clk);
		chk("boost", 8'h03, {6'h00, fans_full_duty, overtemp_signal_active});
		hold(1);
		chk("zero limit", 8'h01, 8'(evs));
		rd(ADDR_TMR_STAT, 8'h01, "flag");
		rd(ADDR_TMR_STAT, 8'h00, "flag cleared");
		assert_time_limit = 8'h02;
		evs = 0;
		hold(12);
		rd(ADDR_TMR_STAT, 8'h01, "short assertion");
		hold(36);
		rd(ADDR_TMR_STAT, 8'h04, "duration");
		chk("limit event", 8'h01, 8'(evs));
		$display("timer test done");
		pin14_func = P14_OTEMP_SEL;
		ot_pin14 = 1'b1;
		repeat (3) @(negedge clk);
		ot_req = 1'b1;
		repeat (2) @(negedge clk);
		chk("pin14 overtemp", 8'h03, {6'h00, fans_full_duty,
			overtemp_signal_active});
		ot_req = 1'b0;
		repeat (2) @(negedge clk);
		chk("pin14 released", 8'h00, {6'h00, fans_full_duty,
			overtemp_signal_active});
		rd(ADDR_TMR_STAT, 8'h01, "pin14 flag");
		$display("pin14 test done");
		close_out;
	end
endmodule
